// [core/pmw_power_watchdog.sv]
// Power-mode control register and watchdog for an 8-bit microcontroller core.
// Assumes the core presents SFR accesses as one-cycle strobes on clk and wake events as levels.
`timescale 1ns/100ps
`default_nettype none
module pmw_power_watchdog
    import pmw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pmw_sfr_s sfr,
    input wire logic irq_pending,
    input wire logic emu_mode,
    input wire pmw_xmove_s xmove,
    input wire logic xmove_rd,
    input wire logic xmove_wr,
    input wire logic ale_core,
    output logic [7:0] sfr_rdata,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic xram_sel,
    output logic ext_rd_n,
    output logic ext_wr_n,
    output logic ale_out,
    output logic mcu_reset,
    output logic chip_reset
);
    // Register state.
    logic [7:0] pctrl_q;
    logic [7:0] pctrl_d;
    logic armed_q;
    logic armed_d;
    logic [7:0] key_q;
    logic [7:0] key_d;
    logic [7:0] reload_q;
    logic [7:0] reload_d;

    // Watchdog counter state.
    logic [13:0] pre_q;
    logic [13:0] pre_d;
    logic [8:0] ticks_q;
    logic [8:0] ticks_d;

    // Registered outputs.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic cpu_en_q;
    logic cpu_en_d;
    logic per_en_q;
    logic per_en_d;
    logic xsel_q;
    logic xsel_d;
    logic rd_n_q;
    logic rd_n_d;
    logic wr_n_q;
    logic wr_n_d;
    logic ale_q;
    logic ale_d;
    logic mrst_q;
    logic mrst_d;
    logic crst_q;
    logic crst_d;

    // Decoded strobes and conditions.
    logic wr_pctrl;
    logic wr_key;
    logic wr_reload;
    logic rd_pctrl;
    logic rd_key;
    logic rd_reload;
    logic load_ok;
    logic expire;
    logic wd_enabled;
    logic wd_due;
    logic low_window;
    logic [8:0] start_ticks;
    logic [8:0] reload_ticks;

    assign wr_pctrl = sfr.wr && (sfr.addr == PMW_PCTRL_ADDR);
    assign wr_key = sfr.wr && (sfr.addr == PMW_KEY_ADDR);
    assign wr_reload = sfr.wr && (sfr.addr == PMW_RELOAD_ADDR);
    assign rd_pctrl = sfr.rd && (sfr.addr == PMW_PCTRL_ADDR);
    assign rd_key = sfr.rd && (sfr.addr == PMW_KEY_ADDR);
    assign rd_reload = sfr.rd && (sfr.addr == PMW_RELOAD_ADDR);
    // A reload is only taken while load enable is already set in the register.
    assign load_ok = wr_reload && pctrl_q[PMW_BIT_LOAD_EN];
    assign wd_enabled = armed_q && (key_q != PMW_KEY_DISABLE);
    // Expiry counts (256 - reload) prescaler periods of 12287 clocks each.
    assign expire = (ticks_q == PMW_ZERO9) && (pre_q == PMW_PRESCALE_LAST);
    // A load in the expiry cycle wins, so a timely reload never races a reset.
    assign wd_due = wd_enabled && expire && !load_ok;
    assign start_ticks = PMW_INTERVAL_BASE - {1'b0, sfr.wdata} - PMW_ONE9;
    assign reload_ticks = PMW_INTERVAL_BASE - {1'b0, reload_q} - PMW_ONE9;
    assign low_window = xmove.addr < PMW_XRAM_LIMIT;

    // Register group: control, arm flag, key and reload value.
    always_comb begin
        pctrl_d = pctrl_q;
        armed_d = armed_q;
        key_d = key_q;
        reload_d = reload_q;
        if (wr_pctrl) begin
            pctrl_d = sfr.wdata;
            if (sfr.wdata[PMW_BIT_LOAD_EN]) begin
                armed_d = 1'b1;
            end
        end
        if (wr_key) begin
            key_d = sfr.wdata;
        end
        if (load_ok) begin
            reload_d = sfr.wdata;
            pctrl_d[PMW_BIT_LOAD_EN] = 1'b0;
        end
        // A wake event clears the mode bits and wins over a same-cycle write, so an
        // interrupt racing the entry instruction cannot leave the core asleep.
        if (irq_pending) begin
            pctrl_d[PMW_BIT_IDLE] = 1'b0;
            pctrl_d[PMW_BIT_POWER_DOWN] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pctrl_q <= PMW_PCTRL_RESET;
            armed_q <= 1'b0;
            key_q <= PMW_KEY_RESET;
            reload_q <= PMW_RELOAD_RESET;
        end else begin
            pctrl_q <= pctrl_d;
            armed_q <= armed_d;
            key_q <= key_d;
            reload_q <= reload_d;
        end
    end

    // Watchdog counter group; a disabling key freezes the count rather than clearing it.
    always_comb begin
        pre_d = pre_q;
        ticks_d = ticks_q;
        if (load_ok) begin
            pre_d = PMW_ZERO14;
            ticks_d = start_ticks;
        end else if (wd_enabled) begin
            if (pre_q == PMW_PRESCALE_LAST) begin
                pre_d = PMW_ZERO14;
                if (ticks_q == PMW_ZERO9) begin
                    ticks_d = reload_ticks;
                end else begin
                    ticks_d = ticks_q - PMW_ONE9;
                end
            end else begin
                pre_d = pre_q + PMW_ONE14;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= PMW_ZERO14;
            ticks_q <= PMW_TICKS_RESET;
        end else begin
            pre_q <= pre_d;
            ticks_q <= ticks_d;
        end
    end

    // Read data group; the answer stands for one cycle and is zero otherwise.
    always_comb begin
        rdata_d = PMW_ZERO8;
        if (rd_pctrl) begin
            rdata_d = pctrl_q;
        end else if (rd_key) begin
            rdata_d = key_q;
        end else if (rd_reload) begin
            rdata_d = reload_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= PMW_ZERO8;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Clock enable group, taken from the next control value so the stop is prompt.
    always_comb begin
        // Power-down stops everything; idle keeps timers and serial controller running.
        cpu_en_d = !pctrl_d[PMW_BIT_IDLE] && !pctrl_d[PMW_BIT_POWER_DOWN];
        per_en_d = !pctrl_d[PMW_BIT_POWER_DOWN];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_en_q <= 1'b1;
            per_en_q <= 1'b1;
        end else begin
            cpu_en_q <= cpu_en_d;
            per_en_q <= per_en_d;
        end
    end

    // External move group.
    always_comb begin
        xsel_d = xmove.valid && low_window && !pctrl_q[PMW_BIT_XRAM_OFF];
        rd_n_d = !(xmove_rd && !xsel_d);
        wr_n_d = !(xmove_wr && !xsel_d);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            xsel_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            xsel_q <= xsel_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
        end
    end

    // Address latch strobe group; holding the last level keeps the pin quiet in power-down, while idle lets it run.
    always_comb begin
        ale_d = ale_core;
        if (pctrl_q[PMW_BIT_POWER_DOWN]) begin
            ale_d = ale_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ale_q <= 1'b0;
        end else begin
            ale_q <= ale_d;
        end
    end

    // Watchdog reset group. The pulse does not clear this block itself; the system
    // must route it back to rst if the registers are to start over.
    always_comb begin
        mrst_d = 1'b0;
        crst_d = 1'b0;
        if (wd_due) begin
            if (emu_mode) begin
                crst_d = 1'b1;
            end else begin
                mrst_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mrst_q <= 1'b0;
            crst_q <= 1'b0;
        end else begin
            mrst_q <= mrst_d;
            crst_q <= crst_d;
        end
    end

    // Every output comes straight from its flip-flop.
    assign sfr_rdata = rdata_q;
    assign cpu_clk_en = cpu_en_q;
    assign periph_clk_en = per_en_q;
    assign xram_sel = xsel_q;
    assign ext_rd_n = rd_n_q;
    assign ext_wr_n = wr_n_q;
    assign ale_out = ale_q;
    assign mcu_reset = mrst_q;
    assign chip_reset = crst_q;
endmodule : pmw_power_watchdog
`default_nettype wire

// [shared/pmw_pkg.sv]
// Package for the power-mode and watchdog block: addresses, bit positions, reset values.
// Assumes an 8-bit special function register bus from the core.
package pmw_pkg;
    localparam logic [7:0] PMW_PCTRL_ADDR = 8'h87;
    localparam logic [7:0] PMW_KEY_ADDR = 8'ha1;
    localparam logic [7:0] PMW_RELOAD_ADDR = 8'ha2;
    localparam logic [7:0] PMW_PCTRL_RESET = 8'h00;
    localparam logic [7:0] PMW_KEY_RESET = 8'h00;
    localparam logic [7:0] PMW_RELOAD_RESET = 8'h00;
    localparam logic [7:0] PMW_KEY_DISABLE = 8'h55;
    localparam logic [8:0] PMW_INTERVAL_BASE = 9'h100;
    localparam logic [13:0] PMW_PRESCALE_LAST = 14'h2ffe;
    localparam logic [8:0] PMW_ZERO9 = 9'h000;
    localparam logic [13:0] PMW_ZERO14 = 14'h0000;
    localparam logic [7:0] PMW_ZERO8 = 8'h00;
    localparam logic [8:0] PMW_ONE9 = 9'h001;
    localparam logic [13:0] PMW_ONE14 = 14'h0001;
    localparam logic [8:0] PMW_TICKS_RESET = PMW_INTERVAL_BASE - {1'b0, PMW_RELOAD_RESET} - PMW_ONE9;
    localparam logic [15:0] PMW_XRAM_LIMIT = 16'h0200;
    localparam int PMW_BIT_XRAM_OFF = 6;
    localparam int PMW_BIT_LOAD_EN = 4;
    localparam int PMW_BIT_POWER_DOWN = 1;
    localparam int PMW_BIT_IDLE = 0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmw_sfr_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } pmw_xmove_s;
endpackage : pmw_pkg

// [verification/pmw_core_model.sv]
// Core-side partner: wake level and a free-running address latch strobe.
// Assumes the bench asks for wake through irq_req; drives on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module pmw_core_model (
    input wire logic clk,
    input wire logic irq_req,
    output logic irq_pending,
    output logic ale_core
);
    initial begin
        irq_pending = 1'b0;
        ale_core = 1'b0;
    end
    // The strobe toggles every cycle so that a frozen output is plainly visible.
    always @(negedge clk) begin
        irq_pending <= irq_req;
        ale_core <= ~ale_core;
    end
endmodule : pmw_core_model
`default_nettype wire

// [verification/pmw_power_watchdog_chk.sv]
// Port checker for the power-mode and watchdog block.
// Assumes it is bound to the block and sees its ports by name.
`timescale 1ns/100ps
`default_nettype none
module pmw_power_watchdog_chk
    import pmw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pmw_sfr_s sfr,
    input wire logic irq_pending,
    input wire logic emu_mode,
    input wire pmw_xmove_s xmove,
    input wire logic [7:0] sfr_rdata,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic xram_sel,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    input wire logic ale_out,
    input wire logic mcu_reset,
    input wire logic chip_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RDATA_QUIET: assert property (!$past(sfr.rd) |-> sfr_rdata == 8'h00)
        else $error("read data outside read");
    AST_XRAM_STROBES: assert property (xram_sel |-> ext_rd_n)
        else $error("read strobe on internal access");
    AST_XRAM_WR_STROBE: assert property (xram_sel |-> ext_wr_n)
        else $error("write strobe on internal access");
    AST_HIGH_RANGE: assert property ($past(xmove.valid && xmove.addr >= PMW_XRAM_LIMIT) |-> !xram_sel)
        else $error("high address went internal");
    AST_PD_ALE: assert property (!periph_clk_en && !$past(periph_clk_en) |-> $stable(ale_out))
        else $error("strobe moved in power-down");
    AST_PD_STOPS_CPU: assert property (!periph_clk_en |-> !cpu_clk_en)
        else $error("processor clocked in power-down");
    AST_WAKE: assert property (irq_pending [*3] |-> cpu_clk_en && periph_clk_en)
        else $error("no wake on interrupt");
    AST_RESET_PULSE: assert property (mcu_reset || chip_reset |=> !mcu_reset && !chip_reset)
        else $error("reset longer than one cycle");
    AST_MCU_ONLY: assert property (mcu_reset |-> !$past(emu_mode))
        else $error("core reset in emulation");
    AST_CHIP_ONLY: assert property (chip_reset |-> $past(emu_mode))
        else $error("chip reset outside emulation");
endmodule : pmw_power_watchdog_chk
`default_nettype wire

// [verification/pmw_power_watchdog_test.sv]
// Self-checking bench for the power-mode and watchdog block.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module pmw_power_watchdog_test;
    import pmw_pkg::*;
    logic clk = 0, rst = 1, irq_req = 0, emu_mode = 0, xmove_rd = 0, xmove_wr = 0;
    logic irq_pending, ale_core, cpu_clk_en, periph_clk_en, xram_sel, ext_rd_n, ext_wr_n;
    logic ale_out, mcu_reset, chip_reset;
    logic [7:0] sfr_rdata;
    pmw_sfr_s sfr = '0;
    pmw_xmove_s xmove = '0;
    int num_errors = 0, total_checks = 0;
    always #5 clk = ~clk;
    pmw_core_model core_u (.clk(clk), .irq_req(irq_req), .irq_pending(irq_pending), .ale_core(ale_core));
    pmw_power_watchdog dut_u (
        .clk(clk), .rst(rst), .sfr(sfr), .irq_pending(irq_pending), .emu_mode(emu_mode),
        .xmove(xmove), .xmove_rd(xmove_rd), .xmove_wr(xmove_wr), .ale_core(ale_core),
        .sfr_rdata(sfr_rdata), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .xram_sel(xram_sel), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ale_out(ale_out),
        .mcu_reset(mcu_reset), .chip_reset(chip_reset));
    task chk(input logic [7:0] v, input logic [7:0] e);
        total_checks++;
        if (v !== e) begin
            $display("unexpected at %0t: got %h want %h", $time, v, e);
            num_errors++;
        end
    endtask : chk
    task conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) sfr <= '{1'b1, 1'b0, a, d};
        @(negedge clk) sfr <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk) sfr <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) chk(sfr_rdata, e);
        sfr <= '0;
    endtask : rd
    // Counts cycles to the next reset pulse; a fixed window absorbs the bus latency.
    task wd(input logic emu, input logic exp, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(negedge clk);
            if ((emu ? chip_reset : mcu_reset) === 1'b1) break;
        end
        chk(8'(n >= 12280 && n <= 12295), 8'(exp));
        if (exp && n == lim) conclude();
    endtask : wd
    task t_regs;
        rd(8'h87, 8'h00);
        rd(8'ha1, 8'h00);
        rd(8'ha2, 8'h00);
        rd(8'h90, 8'h00);
        wr(8'h87, 8'hac);
        rd(8'h87, 8'hac);
        wr(8'h87, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task t_modes;
        logic v;
        for (int m = 1; m < 3; m++) begin
            wr(8'h87, 8'(m));
            repeat (2) @(negedge clk);
            chk(8'(cpu_clk_en), 8'h00);
            chk(8'(periph_clk_en), 8'(m == 1));
            v = ale_out;
            @(negedge clk);
            chk(8'(ale_out), 8'((m == 1) ? !v : v));
            irq_req <= 1'b1;
            repeat (4) @(negedge clk);
            chk(8'(cpu_clk_en), 8'h01);
            irq_req <= 1'b0;
            rd(8'h87, 8'h00);
        end
        $display("test modes done");
    endtask : t_modes
    task t_xram;
        xmove <= '{1'b1, 16'h0100};
        xmove_rd <= 1'b1;
        xmove_wr <= 1'b1;
        repeat (2) @(negedge clk);
        chk(8'(xram_sel), 8'h01);
        chk(8'(ext_rd_n), 8'h01);
        chk(8'(ext_wr_n), 8'h01);
        wr(8'h87, 8'h40);
        repeat (2) @(negedge clk);
        chk(8'(ext_rd_n), 8'h00);
        chk(8'(ext_wr_n), 8'h00);
        xmove <= '{1'b1, 16'h0200};
        wr(8'h87, 8'h00);
        repeat (2) @(negedge clk);
        chk(8'(xram_sel), 8'h00);
        xmove <= '0;
        xmove_rd <= 1'b0;
        xmove_wr <= 1'b0;
        $display("test xram done");
    endtask : t_xram
    task t_watchdog;
        wr(8'h87, 8'h10);
        wr(8'ha2, 8'hff);
        wr(8'ha2, 8'h01);
        wd(1'b0, 1'b1, 13000);
        rd(8'h87, 8'h00);
        wr(8'ha1, 8'h55);
        wr(8'h87, 8'h10);
        wr(8'ha2, 8'hff);
        wd(1'b0, 1'b0, 13000);
        wr(8'ha1, 8'h00);
        emu_mode <= 1'b1;
        wr(8'h87, 8'h10);
        wr(8'ha2, 8'hff);
        wd(1'b1, 1'b1, 13000);
        $display("test watchdog done");
    endtask : t_watchdog
    initial begin
        repeat (8) @(negedge clk);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_xram();
        t_watchdog();
        conclude();
    end
endmodule : pmw_power_watchdog_test
bind pmw_power_watchdog pmw_power_watchdog_chk chk_u (
    .clk(clk), .rst(rst), .sfr(sfr), .irq_pending(irq_pending), .emu_mode(emu_mode),
    .xmove(xmove), .sfr_rdata(sfr_rdata), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .xram_sel(xram_sel), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .ale_out(ale_out), .mcu_reset(mcu_reset), .chip_reset(chip_reset));
`default_nettype wire
